// file: core/boot_seq_cfg.svh
// constants of the two-phase boot sequencer: offsets, fields, reset values, timing
`ifndef BOOT_SEQ_CFG_SVH
`define BOOT_SEQ_CFG_SVH

// *****************************************************************
// register offsets (byte addresses, one word each)
// *****************************************************************
`define REG_BOOT_STATUS 8'h00
`define REG_SECURE_CTRL 8'h04
`define REG_MASTER_ID 8'h08
`define REG_BOOT_CTRL 8'h0c

// *****************************************************************
// field positions
// *****************************************************************
`define STAT_FIRST_BOOT_BIT 0
`define STAT_PHASE_LSB 1
`define STAT_PHASE_MSB 3
`define STAT_STRAP_LSB 4
`define STAT_STRAP_MSB 6
`define STAT_MODE_LSB 7
`define STAT_MODE_MSB 8
`define STAT_VIOLATION_BIT 9
`define STAT_STRAP_BAD_BIT 10
`define SCTL_CLEAR_FLAG_BIT 0
`define SCTL_SELF_RESET_BIT 1
`define MID_CPU_LSB 0
`define MID_CPU_MSB 3
`define MID_DMA_LSB 4
`define MID_DMA_MSB 7
`define BCTL_HANDOFF_BIT 0

// *****************************************************************
// reset values and strap encodings
// *****************************************************************
`define CPU_ID_INIT 4'h1
`define DMA_ID_INIT 4'h2
`define STRAP_SERIAL_LOAD 3'h4
`define STRAP_TWO_WIRE 3'h1
`define STRAP_FOUR_WIRE 3'h0

// *****************************************************************
// timing
// *****************************************************************
`define CLK_PERIOD_PS 4000
`define SELF_RESET_HOLD_NS 40
`define SELF_RESET_HOLD_CYC \
  ((`SELF_RESET_HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// file: core/boot_seq_pkg.sv
// types shared by the boot sequencer modules
`default_nettype none
package boot_seq_pkg;
  typedef logic [3:0] master_id_t;
  typedef logic [2:0] strap_t;

  typedef enum logic [1:0] {
    serial_load_mode,
    functional_two_wire_debug,
    functional_four_wire_debug,
    strap_unrecognised
  } boot_mode_e;

  typedef enum logic [2:0] {
    st_entry_stub,
    st_init_boot,
    st_core_reset,
    st_unsecure_boot,
    st_serial_load,
    st_app
  } boot_phase_e;
endpackage
`default_nettype wire

// file: core/secure_bus_if.sv
// carrier between the sequencer and its secure register bank
`timescale 1ns/100ps
`default_nettype none
interface secure_bus_if;
  import boot_seq_pkg::*;
  logic clear_flag;
  logic write_ids;
  master_id_t cpu_id_wr;
  master_id_t dma_id_wr;
  logic first_boot;
  master_id_t cpu_id;
  master_id_t dma_id;

  modport ctrl
  (
    output clear_flag,
    output write_ids,
    output cpu_id_wr,
    output dma_id_wr,
    input first_boot,
    input cpu_id,
    input dma_id
  );

  modport bank
  (
    input clear_flag,
    input write_ids,
    input cpu_id_wr,
    input dma_id_wr,
    output first_boot,
    output cpu_id,
    output dma_id
  );
endinterface
`default_nettype wire

// file: core/secure_reg_bank.sv
// secure register bank: first-boot flag and bus master identities
`timescale 1ns/100ps
`default_nettype none
`include "boot_seq_cfg.svh"
module secure_reg_bank
(
  input wire logic mclk_in,
  input wire logic rst_in,
  secure_bus_if.bank sec
);
  import boot_seq_pkg::*;

  logic first_boot_reg;
  master_id_t cpu_id_reg;
  master_id_t dma_id_reg;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      first_boot_reg <= 1'b1;
    else if (sec.clear_flag)
      first_boot_reg <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cpu_id_reg <= `CPU_ID_INIT;
      dma_id_reg <= `DMA_ID_INIT;
    end
    else if (sec.write_ids)
    begin
      cpu_id_reg <= sec.cpu_id_wr;
      dma_id_reg <= sec.dma_id_wr;
    end
  end

  assign sec.first_boot = first_boot_reg;
  assign sec.cpu_id = cpu_id_reg;
  assign sec.dma_id = dma_id_reg;
endmodule
`default_nettype wire

// file: core/boot_phase_sequencer.sv
// two-phase boot sequencer with strap sensing and secure-region lock
`timescale 1ns/100ps
`default_nettype none
`include "boot_seq_cfg.svh"

// What this block does
// - leave power-on reset into entry stub
// - first-boot flag set by power-on reset
// - secure region open only while flag set
// - flag set: run device-init code
// - init clears flag, rewrites master identities
// - init completion issues self reset
// - second pass sees flag clear, new identities
// - second pass: stub, unsecure boot, application
// - secure region blocked until power cycle
// - straps latched before leaving reset
// - strap selects boot flow and pin map
// - 100 selects serial load mode
// - serial load waits forever, four-wire debug
// - 001 selects two-wire debug
// - 000 selects four-wire debug
// - strap pins 0 and 1 never released
module boot_phase_sequencer
#(
  parameter int unsigned HOLD_CYCLES = `SELF_RESET_HOLD_CYC
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic strap_pin_0_in,
  input wire logic strap_pin_1_in,
  input wire logic strap_pin_2_in,
  output logic cpu_reset_out,
  output logic rom_entry_stub_out,
  output logic init_code_run_out,
  output logic unsecure_boot_run_out,
  output logic app_run_out,
  output logic secure_open_out,
  output boot_seq_pkg::master_id_t cpu_master_id_out,
  output boot_seq_pkg::master_id_t dma_master_id_out,
  output logic serial_code_load_config_out,
  output logic uart_load_wait_out,
  output logic two_wire_debug_config_out,
  output logic four_wire_debug_config_out,
  output logic strap_pin_2_free_out
);
  import boot_seq_pkg::*;

  // *****************************************************************
  // declarations
  // *****************************************************************
  secure_bus_if sec ();

  boot_phase_e phase_reg;
  boot_phase_e phase_next;
  strap_t strap_reg;
  logic [15:0] hold_cnt_reg;
  logic [15:0] hold_cnt_next;
  logic violation_reg;

  localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYCLES - 1);

  // *****************************************************************
  // strap sensing
  // *****************************************************************
  // capture while reset held
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      strap_reg <= {strap_pin_2_in, strap_pin_1_in, strap_pin_0_in};
  end

  wire sense_on_power_strap_serial = (strap_reg == `STRAP_SERIAL_LOAD);
  wire sense_on_power_strap_two = (strap_reg == `STRAP_TWO_WIRE);
  wire sense_on_power_strap_four = (strap_reg == `STRAP_FOUR_WIRE);

  boot_mode_e mode;
  assign mode = sense_on_power_strap_serial ? serial_load_mode :
                sense_on_power_strap_two ? functional_two_wire_debug :
                sense_on_power_strap_four ? functional_four_wire_debug :
                strap_unrecognised;

  // *****************************************************************
  // register decode
  // *****************************************************************
  wire sel_status = (reg_addr_in == `REG_BOOT_STATUS);
  wire sel_secure = (reg_addr_in == `REG_SECURE_CTRL);
  wire sel_mid = (reg_addr_in == `REG_MASTER_ID);
  wire sel_bctl = (reg_addr_in == `REG_BOOT_CTRL);

  // secure region gated by first-boot flag
  // after the flag drops, only a power cycle reopens it
  wire secure_open = sec.first_boot;
  wire secure_touch = (reg_wr_in | reg_rd_in) & (sel_secure | sel_mid);
  wire secure_blocked = secure_touch & ~secure_open;

  wire wr_secure_ok = reg_wr_in & sel_secure & secure_open;
  wire wr_mid_ok = reg_wr_in & sel_mid & secure_open;
  wire in_init = (phase_reg == st_init_boot);

  assign sec.clear_flag = wr_secure_ok & in_init & reg_wdata_in[`SCTL_CLEAR_FLAG_BIT];
  assign sec.write_ids = wr_mid_ok & in_init;
  assign sec.cpu_id_wr = reg_wdata_in[`MID_CPU_MSB:`MID_CPU_LSB];
  assign sec.dma_id_wr = reg_wdata_in[`MID_DMA_MSB:`MID_DMA_LSB];

  // self reset requested at end of init
  wire self_reset_req = wr_secure_ok & in_init & reg_wdata_in[`SCTL_SELF_RESET_BIT];
  // unsecure boot code hands over to the application
  wire handoff_req = reg_wr_in & sel_bctl & reg_wdata_in[`BCTL_HANDOFF_BIT]
                     & (phase_reg == st_unsecure_boot);

  secure_reg_bank u_bank
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .sec(sec)
  );

  // *****************************************************************
  // boot phase machine
  // *****************************************************************
  always_comb
  begin
    phase_next = phase_reg;
    hold_cnt_next = hold_cnt_reg;
    unique case (phase_reg)
      st_entry_stub:
      begin
        // second pass finds the flag clear
        if (sec.first_boot)
          phase_next = st_init_boot;
        // serial load waits with no timeout
        else if (mode == serial_load_mode)
          phase_next = st_serial_load;
        else
          phase_next = st_unsecure_boot;
      end
      st_init_boot:
      begin
        if (self_reset_req)
        begin
          phase_next = st_core_reset;
          hold_cnt_next = 16'h0000;
        end
      end
      st_core_reset:
      begin
        if (hold_cnt_reg == HOLD_LAST)
          phase_next = st_entry_stub;
        else
          hold_cnt_next = hold_cnt_reg + 16'h0001;
      end
      st_unsecure_boot:
      begin
        if (handoff_req)
          phase_next = st_app;
      end
      // no exit short of a power cycle
      st_serial_load:
        phase_next = st_serial_load;
      st_app:
        phase_next = st_app;
      default:
        phase_next = st_entry_stub;
    endcase
  end

  // power-on reset lands in the entry stub
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      phase_reg <= st_entry_stub;
      hold_cnt_reg <= 16'h0000;
    end
    else
    begin
      phase_reg <= phase_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  // sticky: any access to the locked region; power cycle only clears it
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      violation_reg <= 1'b0;
    else if (secure_blocked)
      violation_reg <= 1'b1;
  end

  // *****************************************************************
  // register read path
  // *****************************************************************
  logic [31:0] status_word;
  logic [31:0] mid_word;
  logic [31:0] rd_mux;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`STAT_FIRST_BOOT_BIT] = sec.first_boot;
    status_word[`STAT_PHASE_MSB:`STAT_PHASE_LSB] = phase_reg;
    status_word[`STAT_STRAP_MSB:`STAT_STRAP_LSB] = strap_reg;
    status_word[`STAT_MODE_MSB:`STAT_MODE_LSB] = mode;
    status_word[`STAT_VIOLATION_BIT] = violation_reg;
    status_word[`STAT_STRAP_BAD_BIT] = (mode == strap_unrecognised);
  end

  always_comb
  begin
    mid_word = 32'h0000_0000;
    mid_word[`MID_CPU_MSB:`MID_CPU_LSB] = sec.cpu_id;
    mid_word[`MID_DMA_MSB:`MID_DMA_LSB] = sec.dma_id;
  end

  // locked reads of the identities return zero
  assign rd_mux = sel_status ? status_word :
                  (sel_mid & secure_open) ? mid_word :
                  32'h0000_0000;

  // data stand only in the cycle after the read strobe
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rd_mux;
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // *****************************************************************
  // registered outputs
  // *****************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      cpu_reset_out <= 1'b1;
      rom_entry_stub_out <= 1'b0;
      init_code_run_out <= 1'b0;
      unsecure_boot_run_out <= 1'b0;
      app_run_out <= 1'b0;
      secure_open_out <= 1'b0;
      cpu_master_id_out <= `CPU_ID_INIT;
      dma_master_id_out <= `DMA_ID_INIT;
      serial_code_load_config_out <= 1'b0;
      uart_load_wait_out <= 1'b0;
      two_wire_debug_config_out <= 1'b0;
      four_wire_debug_config_out <= 1'b0;
      strap_pin_2_free_out <= 1'b0;
    end
    else
    begin
      // core held in reset during hold window
      cpu_reset_out <= (phase_next == st_core_reset);
      rom_entry_stub_out <= (phase_next == st_entry_stub);
      // init code selected in the first pass
      init_code_run_out <= (phase_next == st_init_boot);
      unsecure_boot_run_out <= (phase_next == st_unsecure_boot);
      app_run_out <= (phase_next == st_app);
      secure_open_out <= secure_open & ~sec.clear_flag;
      // bus accesses carry the current identity
      cpu_master_id_out <= sec.cpu_id;
      dma_master_id_out <= sec.dma_id;
      // pin map follows the latched strap
      serial_code_load_config_out <= (mode == serial_load_mode);
      uart_load_wait_out <= (phase_next == st_serial_load);
      // serial load also maps four-wire debug
      four_wire_debug_config_out <= (mode == serial_load_mode) |
                                    (mode == functional_four_wire_debug) |
                                    (mode == strap_unrecognised);
      two_wire_debug_config_out <= (mode == functional_two_wire_debug);
      // pin 2 released once the application phase is entered
      // pins 0 and 1 are never released
      strap_pin_2_free_out <= (phase_next == st_app);
    end
  end
endmodule
`default_nettype wire

// file: verification/strap_board_model.sv
// board strap resistors, with strap pin 2 reused as an output after power-up
`timescale 1ns/100ps
`default_nettype none
module strap_board_model
(
  input wire logic mclk_in,
  input wire logic power_up_in,
  input wire logic reuse_in,
  input wire logic [2:0] code_in,
  output logic strap_pin_0_out,
  output logic strap_pin_1_out,
  output logic strap_pin_2_out
);
  logic toggle_reg;

  always_ff @(posedge mclk_in)
    toggle_reg <= power_up_in ? 1'b0 : ~toggle_reg;

  assign strap_pin_0_out = code_in[0];
  assign strap_pin_1_out = code_in[1];
  assign strap_pin_2_out = (power_up_in || !reuse_in) ? code_in[2] : toggle_reg;
endmodule
`default_nettype wire

// file: verification/boot_phase_sequencer_assertions.sv
// port checker of the two-phase boot sequencer
`timescale 1ns/100ps
`default_nettype none
module boot_seq_checker
#(
  parameter int unsigned HOLD_CYCLES = 10
)
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic strap_pin_0_in,
  input wire logic strap_pin_1_in,
  input wire logic strap_pin_2_in,
  input wire logic cpu_reset_out,
  input wire logic rom_entry_stub_out,
  input wire logic init_code_run_out,
  input wire logic app_run_out,
  input wire logic secure_open_out,
  input wire boot_seq_pkg::master_id_t cpu_master_id_out,
  input wire boot_seq_pkg::master_id_t dma_master_id_out,
  input wire logic serial_code_load_config_out,
  input wire logic uart_load_wait_out,
  input wire logic two_wire_debug_config_out,
  input wire logic four_wire_debug_config_out,
  input wire logic strap_pin_2_free_out
);
  import boot_seq_pkg::*;
  logic [2:0] strap_seen;
  logic rst_d;
  logic [7:0] hold_cnt;

  // power-on reset cycles are not counted, only the self-issued hold
  always_ff @(posedge mclk_in)
  begin
    rst_d <= rst_in;
    if (rst_in)
      strap_seen <= {strap_pin_2_in, strap_pin_1_in, strap_pin_0_in};
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in || !cpu_reset_out)
      hold_cnt <= 8'h00;
    else if (!rst_d)
      hold_cnt <= hold_cnt + 8'h01;
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // *****************************************************************
  // assertions
  // *****************************************************************
  a_serial_map: assert property (!$past(rst_in) |->
    serial_code_load_config_out == (strap_seen == 3'h4)) else $error("serial load map wrong");
  a_two_wire_map: assert property (!$past(rst_in) |->
    two_wire_debug_config_out == (strap_seen == 3'h1)) else $error("two-wire map wrong");
  a_four_wire_map: assert property (!$past(rst_in) |->
    four_wire_debug_config_out == (strap_seen != 3'h1)) else $error("four-wire map wrong");
  a_self_reset_hold: assert property ($fell(cpu_reset_out) && hold_cnt != 8'h00 |->
    hold_cnt == HOLD_CYCLES) else $error("self reset hold length wrong");
  a_stub_after_hold: assert property ($fell(cpu_reset_out) && hold_cnt != 8'h00 |->
    rom_entry_stub_out ##1 !rom_entry_stub_out) else $error("entry stub not run once");
  a_init_after_por: assert property ($fell(rst_in) |=>
    init_code_run_out && !cpu_reset_out ##[0:1] secure_open_out) else $error("no init boot");
  a_app_locks_secure: assert property (app_run_out |->
    !secure_open_out && !init_code_run_out && strap_pin_2_free_out) else $error("app unlocked");
  a_app_kept: assert property (app_run_out |=> app_run_out)
    else $error("application phase left");
  a_ids_frozen: assert property (!init_code_run_out && !$past(init_code_run_out) |->
    $stable(cpu_master_id_out) && $stable(dma_master_id_out)) else $error("ids changed");
  a_uart_wait_map: assert property (uart_load_wait_out |->
    serial_code_load_config_out && four_wire_debug_config_out) else $error("uart wait map");
  a_rdata_cause: assert property (reg_rdata_out != 32'h0 |-> $past(reg_rd_in))
    else $error("read data without read");
endmodule

bind boot_phase_sequencer boot_seq_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.mclk_in, .rst_in,
  .reg_rd_in, .reg_rdata_out, .strap_pin_0_in, .strap_pin_1_in, .strap_pin_2_in,
  .cpu_reset_out, .rom_entry_stub_out, .init_code_run_out, .app_run_out, .secure_open_out,
  .cpu_master_id_out, .dma_master_id_out, .serial_code_load_config_out, .uart_load_wait_out,
  .two_wire_debug_config_out, .four_wire_debug_config_out, .strap_pin_2_free_out);
`default_nettype wire

// file: verification/two_phase_boot_mode_select_test.sv
// self-checking bench of the two-phase boot sequencer
`timescale 1ns/100ps
`default_nettype none
`include "boot_seq_cfg.svh"
`define CHECK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module two_phase_boot_mode_select_test;
  import boot_seq_pkg::*;
  localparam int unsigned HOLD = 4;
  logic mclk_in, rst_in, reg_wr_in, reg_rd_in, reuse;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [2:0] code;
  logic strap_pin_0_in, strap_pin_1_in, strap_pin_2_in;
  logic cpu_reset_out, rom_entry_stub_out, init_code_run_out, unsecure_boot_run_out;
  logic app_run_out, secure_open_out, serial_code_load_config_out, uart_load_wait_out;
  logic two_wire_debug_config_out, four_wire_debug_config_out, strap_pin_2_free_out;
  master_id_t cpu_master_id_out, dma_master_id_out;
  integer seed = 34572;
  int bad_count = 0;
  int comparisons = 0;

  boot_phase_sequencer #(.HOLD_CYCLES(HOLD)) DUT (.mclk_in, .rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .strap_pin_0_in, .strap_pin_1_in,
    .strap_pin_2_in, .cpu_reset_out, .rom_entry_stub_out, .init_code_run_out,
    .unsecure_boot_run_out, .app_run_out, .secure_open_out, .cpu_master_id_out,
    .dma_master_id_out, .serial_code_load_config_out, .uart_load_wait_out,
    .two_wire_debug_config_out, .four_wire_debug_config_out, .strap_pin_2_free_out);
  strap_board_model board (.mclk_in, .power_up_in(rst_in), .reuse_in(reuse), .code_in(code),
    .strap_pin_0_out(strap_pin_0_in), .strap_pin_1_out(strap_pin_1_in),
    .strap_pin_2_out(strap_pin_2_in));

  function automatic logic [31:0] exp_stat(input logic f, input logic [2:0] ph,
    input logic [2:0] s, input logic v);
    logic [1:0] m;
    m = (s == 3'h4) ? 2'h0 : (s == 3'h1) ? 2'h1 : (s == 3'h0) ? 2'h2 : 2'h3;
    return {21'h0, m == 2'h3, v, m, s, ph, f};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 `CHECK(n, e, reg_rdata_out)
  endtask

  // *****************************************************************
  // one power cycle with both boot passes
  // *****************************************************************
  task automatic boot(input logic [2:0] c);
    logic [7:0] ids;
    ids = 8'($random(seed));
    @(posedge mclk_in);
    code <= c;
    reuse <= 1'b0;
    rst_in <= 1'b1;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    #1 `CHECK("init run", 1'b1, init_code_run_out)
    `CHECK("serial map", c == 3'h4, serial_code_load_config_out)
    `CHECK("two map", c == 3'h1, two_wire_debug_config_out)
    `CHECK("four map", c != 3'h1, four_wire_debug_config_out)
    chk_rd("status init", `REG_BOOT_STATUS, exp_stat(1'b1, 3'h1, c, 1'b0));
    chk_rd("ids reset", `REG_MASTER_ID, {24'h0, `DMA_ID_INIT, `CPU_ID_INIT});
    wr(`REG_MASTER_ID, {24'h0, ids});
    chk_rd("ids written", `REG_MASTER_ID, {24'h0, ids});
    wr(`REG_SECURE_CTRL, 32'h3);
    code <= ~c;
    reuse <= 1'b1;
    #1 `CHECK("core reset", 1'b1, cpu_reset_out)
    repeat (HOLD) @(posedge mclk_in);
    #1 `CHECK("stub", 1'b1, rom_entry_stub_out)
    @(posedge mclk_in);
    #1 `CHECK("uart wait", c == 3'h4, uart_load_wait_out)
    if (c == 3'h4)
    begin
      repeat (50) @(posedge mclk_in);
      #1 `CHECK("still waiting", 1'b1, uart_load_wait_out)
      chk_rd("status load", `REG_BOOT_STATUS, exp_stat(1'b0, 3'h4, c, 1'b0));
      return;
    end
    `CHECK("unsecure run", 1'b1, unsecure_boot_run_out)
    `CHECK("cpu id", ids[3:0], cpu_master_id_out)
    `CHECK("dma id", ids[7:4], dma_master_id_out)
    chk_rd("status pass 2", `REG_BOOT_STATUS, exp_stat(1'b0, 3'h3, c, 1'b0));
    chk_rd("ids blocked", `REG_MASTER_ID, 32'h0);
    wr(`REG_MASTER_ID, 32'($random(seed)));
    #1 `CHECK("open", 1'b0, secure_open_out)
    wr(`REG_BOOT_CTRL, 32'h1);
    #1 `CHECK("app run", 1'b1, app_run_out)
    `CHECK("pin 2 free", 1'b1, strap_pin_2_free_out)
    `CHECK("cpu id kept", ids[3:0], cpu_master_id_out)
    chk_rd("status app", `REG_BOOT_STATUS, exp_stat(1'b0, 3'h5, c, 1'b1));
    chk_rd("unmapped", 8'h10, 32'h0);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    logic [2:0] u;
    rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    code = 3'h0;
    reuse = 1'b0;
    boot(`STRAP_SERIAL_LOAD);
    boot(`STRAP_TWO_WIRE);
    boot(`STRAP_FOUR_WIRE);
    u = 3'($random(seed));
    if (u inside {3'h0, 3'h1, 3'h4})
      u = 3'h7;
    boot(u);
    report_and_stop();
  end
endmodule
`default_nettype wire
